// >>> verilog/channel_monitor_flag_bank_consts.svh
// byte offsets, field positions and reset values of the flag bank
`ifndef CHANNEL_MONITOR_FLAG_BANK_CONSTS_SVH
`define CHANNEL_MONITOR_FLAG_BANK_CONSTS_SVH
`define RX_POWER_FLAGS_CH1_CH2 8'h09
`define RX_POWER_FLAGS_CH3_CH4 8'h0A
`define TX_BIAS_FLAGS_CH1_CH2  8'h0B
`define TX_BIAS_FLAGS_CH3_CH4  8'h0C
`define TX_POWER_FLAGS_CH1_CH2 8'h0D
`define TX_POWER_FLAGS_CH3_CH4 8'h0E
`define RSVD_FLAGS_FIRST       8'h0F
`define VENDOR_FLAGS_LAST      8'h15
`define MODULE_TEMP_HIGH_BYTE  8'h16
`define MODULE_TEMP_LOW_BYTE   8'h17
`define SUPPLY_VOLT_HIGH_BYTE  8'h1A
`define SUPPLY_VOLT_LOW_BYTE   8'h1B
`define FLAG_RESET             8'h00
`define THR_HIGH_ALARM         2'h0
`define THR_LOW_ALARM          2'h1
`define THR_HIGH_WARN          2'h2
`define THR_LOW_WARN           2'h3
`define BIT_HIGH_ALARM         3
`define BIT_LOW_ALARM          2
`define BIT_HIGH_WARN          1
`define BIT_LOW_WARN           0
`endif

// >>> verilog/channel_monitor_flag_bank_pkg.sv
// types of the flag bank
`default_nettype none
package channel_monitor_flag_bank_pkg;
  typedef enum logic [2:0] {
    L_IDLE, L_ADDR, L_OFFS, L_WDATA, L_ACK, L_SEND, L_MACK
  } link_state_t;
  typedef logic [3:0][15:0] quad_word_t;
endpackage : channel_monitor_flag_bank_pkg
`default_nettype wire

// >>> verilog/channel_monitor_flag_bank.sv
// latched channel flags and module monitors behind the two-wire port
`include "channel_monitor_flag_bank_consts.svh"
`default_nettype none
// What this block does
// - byte 9 holds rx power flags, ch1 high nibble, ch2 low nibble
// - byte 10 holds rx power flags, ch3 high nibble, ch4 low nibble
// - byte 11 holds tx bias flags, ch1 high nibble, ch2 low nibble
// - byte 12 holds tx bias flags, ch3 high nibble, ch4 low nibble
// - byte 13 holds tx power flags, ch1 high nibble, ch2 low nibble
// - byte 14 holds tx power flags, ch3 high nibble, ch4 low nibble
// - bytes 15 to 18 are reserved and carry no indication
// - bytes 19 to 21 are vendor specific, outside the flag set
// - monitor values are 16 bits, high byte at the lower address
// - temperature in bytes 22 and 23; bytes 24, 25 reserved
// - supply in bytes 26 and 27; 28, 29 reserved; 30-33 vendor
// - flags read zero after reset and set only on their condition
// - flags stay set until a read covers them or reset
module channel_monitor_flag_bank
  import channel_monitor_flag_bank_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h50
)(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       link_clk_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  input  wire logic [15:0] temp_in,
  input  wire logic [15:0] vcc_in,
  input  wire quad_word_t rx_power_in,
  input  wire quad_word_t tx_bias_in,
  input  wire quad_word_t tx_power_in,
  input  wire quad_word_t rx_power_thr_in,
  input  wire quad_word_t tx_bias_thr_in,
  input  wire quad_word_t tx_power_thr_in
);

  if (DEV_ADDR[6:3] == 4'h0 || DEV_ADDR[6:3] == 4'hF)
  begin : g_bad_addr
    $error("device address lies in a reserved range");
  end

  // limit compare, nibble order high alarm, low alarm, high/low warning
  function automatic logic [3:0] limit_check(input logic [15:0] v,
                                             input quad_word_t t);
    return {v > t[`THR_HIGH_ALARM], v < t[`THR_LOW_ALARM],
            v > t[`THR_HIGH_WARN], v < t[`THR_LOW_WARN]};
  endfunction : limit_check

  function automatic logic [7:0] pair_flags(input quad_word_t v,
                                            input quad_word_t t,
                                            input int p);
    return {limit_check(v[2*p], t), limit_check(v[2*p+1], t)};
  endfunction : pair_flags

  // core clock domain
  logic [5:0][7:0] flag_q;
  logic [5:0][7:0] cond;
  logic [5:0][7:0] clr;
  logic [2:0]      req_sync_q;
  logic            req_seen_q;
  logic            ack_tgl_q;
  logic [7:0]      rd_data_q;
  logic [7:0]      temp_lo_snap_q;
  logic [7:0]      vcc_lo_snap_q;
  logic            temp_snap_ok_q;
  logic            vcc_snap_ok_q;
  logic            new_req;
  logic [7:0]      core_addr;

  // link clock domain
  link_state_t     state_q;
  link_state_t     next_q;
  logic [2:0]      scl_s_q;
  logic [2:0]      sda_s_q;
  logic            scl_f_q;
  logic            sda_f_q;
  logic [7:0]      shift_q;
  logic [7:0]      tx_q;
  logic [7:0]      ptr_q;
  logic [7:0]      fetch_q;
  logic [2:0]      cnt_q;
  logic            phase_q;
  logic            acked_q;
  logic            sda_oe_q;
  logic            req_tgl_q;
  logic [2:0]      ack_sync_q;
  logic            ack_seen_q;
  logic            scl_rise;
  logic            scl_fall;
  logic            start_seen;
  logic            stop_seen;
  logic [7:0]      in_byte;

  always_comb
  begin
    for (int p = 0; p < 2; p++)
    begin
      cond[p]     = pair_flags(rx_power_in, rx_power_thr_in, p);
      cond[2 + p] = pair_flags(tx_bias_in, tx_bias_thr_in, p);
      cond[4 + p] = pair_flags(tx_power_in, tx_power_thr_in, p);
    end
  end

  // request toggle from the link, three stages, counted when two agree
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      req_sync_q <= 3'h0;
    else
      req_sync_q <= {req_sync_q[1:0], req_tgl_q};
  end

  assign new_req   = (req_sync_q[1] == req_sync_q[2]) &&
                     (req_sync_q[2] != req_seen_q);
  assign core_addr = ptr_q;

  always_comb
  begin
    for (int b = 0; b < 6; b++)
      clr[b] = (new_req && core_addr == `RX_POWER_FLAGS_CH1_CH2 + 8'(b))
               ? 8'hFF : 8'h00;
  end

  // set wins over the clear of the same cycle
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      flag_q <= {6{`FLAG_RESET}};
    else
      flag_q <= (flag_q & ~clr) | cond;
  end

  // read service: answer byte and toggle back on the same edge
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      req_seen_q <= 1'b0;
      ack_tgl_q  <= 1'b0;
      rd_data_q  <= 8'h00;
    end
    else if (new_req)
    begin
      req_seen_q <= req_sync_q[2];
      ack_tgl_q  <= ~ack_tgl_q;
      if (core_addr >= `RX_POWER_FLAGS_CH1_CH2 &&
          core_addr <= `TX_POWER_FLAGS_CH3_CH4)
        rd_data_q <= flag_q[3'(core_addr - `RX_POWER_FLAGS_CH1_CH2)];
      else
      begin
        unique case (core_addr)
          `MODULE_TEMP_HIGH_BYTE: rd_data_q <= temp_in[15:8];
          `MODULE_TEMP_LOW_BYTE:
            rd_data_q <= temp_snap_ok_q ? temp_lo_snap_q : temp_in[7:0];
          `SUPPLY_VOLT_HIGH_BYTE: rd_data_q <= vcc_in[15:8];
          `SUPPLY_VOLT_LOW_BYTE:
            rd_data_q <= vcc_snap_ok_q ? vcc_lo_snap_q : vcc_in[7:0];
          default:                rd_data_q <= 8'h00;
        endcase
      end
    end
  end

  // low byte held from the sample of the high byte
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      temp_lo_snap_q <= 8'h00;
      vcc_lo_snap_q  <= 8'h00;
      temp_snap_ok_q <= 1'b0;
      vcc_snap_ok_q  <= 1'b0;
    end
    else if (new_req)
    begin
      temp_snap_ok_q <= core_addr == `MODULE_TEMP_HIGH_BYTE;
      vcc_snap_ok_q  <= core_addr == `SUPPLY_VOLT_HIGH_BYTE;
      if (core_addr == `MODULE_TEMP_HIGH_BYTE)
        temp_lo_snap_q <= temp_in[7:0];
      if (core_addr == `SUPPLY_VOLT_HIGH_BYTE)
        vcc_lo_snap_q <= vcc_in[7:0];
    end
  end

  // pin and answer synchronisers on the link clock
  always_ff @(posedge link_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      scl_s_q    <= 3'h7;
      sda_s_q    <= 3'h7;
      scl_f_q    <= 1'b1;
      sda_f_q    <= 1'b1;
      ack_sync_q <= 3'h0;
    end
    else
    begin
      scl_s_q    <= {scl_s_q[1:0], scl_in};
      sda_s_q    <= {sda_s_q[1:0], sda_in};
      ack_sync_q <= {ack_sync_q[1:0], ack_tgl_q};
      if (scl_s_q[1] == scl_s_q[2])
        scl_f_q <= scl_s_q[2];
      if (sda_s_q[1] == sda_s_q[2])
        sda_f_q <= sda_s_q[2];
    end
  end

  assign scl_rise   = (scl_s_q[1] == scl_s_q[2]) && scl_s_q[2] && !scl_f_q;
  assign scl_fall   = (scl_s_q[1] == scl_s_q[2]) && !scl_s_q[2] && scl_f_q;
  assign start_seen = scl_f_q && (sda_s_q[1] == sda_s_q[2]) &&
                      !sda_s_q[2] && sda_f_q;
  assign stop_seen  = scl_f_q && (sda_s_q[1] == sda_s_q[2]) &&
                      sda_s_q[2] && !sda_f_q;
  assign in_byte    = {shift_q[6:0], sda_f_q};

  // fetched byte taken once the answer toggle has settled
  always_ff @(posedge link_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ack_seen_q <= 1'b0;
      fetch_q    <= 8'h00;
    end
    else if (ack_sync_q[1] == ack_sync_q[2] && ack_sync_q[2] != ack_seen_q)
    begin
      ack_seen_q <= ack_sync_q[2];
      fetch_q    <= rd_data_q;
    end
  end

  // two-wire slave: address, offset, ignored writes, sequential reads
  always_ff @(posedge link_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_q   <= L_IDLE;
      next_q    <= L_IDLE;
      shift_q   <= 8'h00;
      tx_q      <= 8'h00;
      ptr_q     <= 8'h00;
      cnt_q     <= 3'h0;
      phase_q   <= 1'b0;
      acked_q   <= 1'b0;
      sda_oe_q  <= 1'b0;
      req_tgl_q <= 1'b0;
    end
    else if (stop_seen)
    begin
      state_q  <= L_IDLE;
      sda_oe_q <= 1'b0;
    end
    else if (start_seen)
    begin
      state_q  <= L_ADDR;
      cnt_q    <= 3'h0;
      sda_oe_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        L_IDLE: ;
        L_ADDR, L_OFFS, L_WDATA:
          if (scl_rise)
          begin
            shift_q <= in_byte;
            cnt_q   <= cnt_q + 3'h1;
            if (cnt_q == 3'h7)
            begin
              state_q <= L_ACK;
              phase_q <= 1'b0;
              if (state_q == L_ADDR)
              begin
                if (in_byte[7:1] != DEV_ADDR)
                  state_q <= L_IDLE;
                next_q <= in_byte[0] ? L_SEND : L_OFFS;
              end
              else
              begin
                next_q <= L_WDATA;
                ptr_q  <= (state_q == L_OFFS) ? in_byte : ptr_q + 8'h01;
              end
            end
          end
        L_ACK:
          if (scl_fall && !phase_q)
          begin
            sda_oe_q <= 1'b1;
            phase_q  <= 1'b1;
            if (next_q == L_SEND)
              req_tgl_q <= ~req_tgl_q;
          end
          else if (scl_fall)
          begin
            state_q  <= next_q;
            cnt_q    <= (next_q == L_SEND) ? 3'h1 : 3'h0;
            tx_q     <= {fetch_q[6:0], 1'b0};
            sda_oe_q <= (next_q == L_SEND) ? ~fetch_q[7] : 1'b0;
          end
        L_SEND:
          if (scl_fall)
          begin
            cnt_q    <= cnt_q + 3'h1;
            tx_q     <= {tx_q[6:0], 1'b0};
            sda_oe_q <= (cnt_q == 3'h0) ? 1'b0 : ~tx_q[7];
            if (cnt_q == 3'h0)
              state_q <= L_MACK;
          end
        L_MACK:
          if (scl_rise)
          begin
            acked_q <= !sda_f_q;
            if (!sda_f_q)
            begin
              ptr_q     <= ptr_q + 8'h01;
              req_tgl_q <= ~req_tgl_q;
            end
          end
          else if (scl_fall)
          begin
            state_q  <= acked_q ? L_SEND : L_IDLE;
            cnt_q    <= 3'h1;
            tx_q     <= {fetch_q[6:0], 1'b0};
            sda_oe_q <= acked_q && !fetch_q[7];
          end
      endcase
    end
  end

  assign sda_out    = 1'b0;
  assign sda_oe_out = sda_oe_q;

  AST_RX1_HIGH_ALARM: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    rx_power_in[0] > rx_power_thr_in[`THR_HIGH_ALARM] |=> flag_q[0][7])
    else $error("rx ch1 high alarm not latched");
  AST_RX4_LOW_WARN: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    rx_power_in[3] < rx_power_thr_in[`THR_LOW_WARN] |=> flag_q[1][0])
    else $error("rx ch4 low warning not latched");
  AST_BIAS2_HIGH_WARN: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    tx_bias_in[1] > tx_bias_thr_in[`THR_HIGH_WARN] |=> flag_q[2][1])
    else $error("bias ch2 high warning not latched");
  AST_BIAS3_LOW_ALARM: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    tx_bias_in[2] < tx_bias_thr_in[`THR_LOW_ALARM] |=> flag_q[3][6])
    else $error("bias ch3 low alarm not latched");
  AST_TXP1_HIGH_WARN: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    tx_power_in[0] > tx_power_thr_in[`THR_HIGH_WARN] |=> flag_q[4][5])
    else $error("tx power ch1 high warning not latched");
  AST_TXP4_HIGH_ALARM: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    tx_power_in[3] > tx_power_thr_in[`THR_HIGH_ALARM] |=> flag_q[5][3])
    else $error("tx power ch4 high alarm not latched");
  AST_RSVD_READS_ZERO: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    new_req && core_addr >= `RSVD_FLAGS_FIRST && core_addr <= `VENDOR_FLAGS_LAST
    |=> rd_data_q == 8'h00)
    else $error("reserved flag byte read nonzero");
  AST_TEMP_HIGH_BYTE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    new_req && core_addr == `MODULE_TEMP_HIGH_BYTE
    |=> rd_data_q == $past(temp_in[15:8]))
    else $error("temperature high byte wrong");
  AST_VCC_HIGH_BYTE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    new_req && core_addr == `SUPPLY_VOLT_HIGH_BYTE
    |=> rd_data_q == $past(vcc_in[15:8]))
    else $error("supply high byte wrong");
  AST_FLAG_ONLY_ON_COND: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(flag_q[0][7])
    |-> $past(rx_power_in[0] > rx_power_thr_in[`THR_HIGH_ALARM]))
    else $error("flag rose without its condition");
  AST_FLAG_HOLDS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    flag_q[0][7] && !(new_req && core_addr == `RX_POWER_FLAGS_CH1_CH2)
    |=> flag_q[0][7])
    else $error("flag dropped without a covering read");
  AST_FLAG_CLEAR_ON_READ: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    new_req && core_addr == `RX_POWER_FLAGS_CH1_CH2 && flag_q[0][7]
    ##1 !$past(cond[0][7]) |-> !flag_q[0][7])
    else $error("flag not cleared by read");
  AST_TEMP_SNAPSHOT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    new_req && core_addr == `MODULE_TEMP_HIGH_BYTE
    |=> temp_lo_snap_q == $past(temp_in[7:0]) && temp_snap_ok_q)
    else $error("temperature low byte not captured");
  COV_FLAG_READ: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    new_req && core_addr == `RX_POWER_FLAGS_CH1_CH2 && flag_q[0] != 8'h00);
  COV_TEMP_PAIR: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    new_req && core_addr == `MODULE_TEMP_LOW_BYTE && temp_snap_ok_q);
  COV_LINK_READ: cover property (@(posedge link_clk_in) disable iff (!rst_n_in)
    state_q == L_SEND && scl_fall);

endmodule : channel_monitor_flag_bank
`default_nettype wire

// >>> test/host_twi_model.sv
// host management controller model on the two-wire port
`default_nettype none
module host_twi_model #(
  parameter int         QTR      = 28,
  parameter logic [6:0] DEV_ADDR = 7'h50
)(
  input  wire logic clk_in,
  input  wire logic sda_in,
  output var logic  scl_out,
  output var logic  sda_low_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    scl_out     = 1'b1;
    sda_low_out = 1'b0;
  end

  task automatic qtr;
    repeat (QTR) @(posedge clk_in);
  endtask : qtr

  // also serves as repeated start
  task automatic start_cond;
    sda_low_out <= 1'b0;
    qtr();
    scl_out <= 1'b1;
    qtr();
    sda_low_out <= 1'b1;
    qtr();
    scl_out <= 1'b0;
    qtr();
  endtask : start_cond

  task automatic stop_cond;
    sda_low_out <= 1'b1;
    qtr();
    scl_out <= 1'b1;
    qtr();
    sda_low_out <= 1'b0;
    qtr();
  endtask : stop_cond

  task automatic bit_io(input logic b, output logic r);
    sda_low_out <= !b;
    qtr();
    scl_out <= 1'b1;
    qtr();
    r = sda_in;
    qtr();
    scl_out <= 1'b0;
    qtr();
  endtask : bit_io

  task automatic byte_io(input logic [7:0] w, input logic ack_host,
                         output logic [7:0] r, output logic ack_dev);
    for (int i = 7; i >= 0; i--)
      bit_io(w[i], r[i]);
    bit_io(ack_host, ack_dev);
  endtask : byte_io

  // offset write, repeated start, n sequential reads, nack on the last
  task automatic read_seq(input logic [7:0] off, input int n,
                          output logic [7:0] d [32], output logic nak);
    logic       a;
    logic [7:0] junk;
    nak = 1'b0;
    start_cond();
    byte_io({DEV_ADDR, 1'b0}, 1'b1, junk, a);
    nak |= a;
    byte_io(off, 1'b1, junk, a);
    nak |= a;
    start_cond();
    byte_io({DEV_ADDR, 1'b1}, 1'b1, junk, a);
    nak |= a;
    for (int i = 0; i < n; i++)
      byte_io(8'hFF, i == n - 1, d[i], a);
    stop_cond();
  endtask : read_seq
endmodule : host_twi_model
`default_nettype wire

// >>> test/testbench.sv
// self-checking bench for the channel flag bank
`include "channel_monitor_flag_bank_consts.svh"
`default_nettype none
module testbench
  import channel_monitor_flag_bank_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed
  {
    logic [1:0]  kind;
    logic [1:0]  ch;
    logic [15:0] val;
    logic [3:0]  nib;
  } row_t;

  localparam logic [15:0] NORM = 16'h8000;
  localparam logic [7:0]  BASE = `RX_POWER_FLAGS_CH1_CH2;
  logic        clk_in, link_clk_in, rst_n_in;
  logic        scl, host_low, sda_line, sda_oe, sda_drv, nak;
  logic [15:0] temp, vcc;
  quad_word_t  rx, bias, txp, thr;
  logic [7:0]  rd [32];
  logic [7:0]  want, a;
  row_t        rows [12];
  int          n_errors = 0;
  int          tests_run = 0;
  int          cycles = 0;

  assign sda_line = !(host_low || sda_oe);

  channel_monitor_flag_bank i_dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .link_clk_in(link_clk_in),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_drv),
    .sda_oe_out(sda_oe), .temp_in(temp), .vcc_in(vcc),
    .rx_power_in(rx), .tx_bias_in(bias), .tx_power_in(txp),
    .rx_power_thr_in(thr), .tx_bias_thr_in(thr), .tx_power_thr_in(thr)
  );

  host_twi_model i_host (
    .clk_in(clk_in), .sda_in(sda_line), .scl_out(scl),
    .sda_low_out(host_low)
  );

  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  initial
  begin
    link_clk_in = 1'b0;
    #3.1;
    forever #7.5 link_clk_in = ~link_clk_in;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 98000)
    begin
      n_errors = n_errors + 1;
      close_out();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t %s seen %h want %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic set_val(input logic [1:0] k, input logic [1:0] c,
                         input logic [15:0] v);
    @(posedge clk_in);
    case (k)
      2'h0: rx[c] <= v;
      2'h1: bias[c] <= v;
      default: txp[c] <= v;
    endcase
    repeat (4) @(posedge clk_in);
  endtask : set_val

  initial
  begin
    rst_n_in = 1'b0;
    temp     = 16'h1234;
    vcc      = 16'h5678;
    rx       = {4{NORM}};
    bias     = {4{NORM}};
    txp      = {4{NORM}};
    thr      = {16'h2000, 16'hE000, 16'h1000, 16'hF000};
    rows = '{'{0, 0, 16'hF800, 4'hA}, '{0, 1, 16'h0800, 4'h5},
             '{0, 2, 16'hE800, 4'h2}, '{0, 3, 16'h1800, 4'h1},
             '{1, 0, 16'h0800, 4'h5}, '{1, 1, 16'hE800, 4'h2},
             '{1, 2, 16'h1800, 4'h1}, '{1, 3, 16'hF800, 4'hA},
             '{2, 0, 16'hE800, 4'h2}, '{2, 1, 16'h1800, 4'h1},
             '{2, 2, 16'hF800, 4'hA}, '{2, 3, 16'h0800, 4'h5}};
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (20) @(posedge clk_in);
    // latched flag survives the condition going away
    foreach (rows[i])
    begin
      set_val(rows[i].kind, rows[i].ch, rows[i].val);
      set_val(rows[i].kind, rows[i].ch, NORM);
      a = BASE + {5'h0, rows[i].kind, rows[i].ch[1]};
      want = rows[i].ch[0] ? {4'h0, rows[i].nib} : {rows[i].nib, 4'h0};
      i_host.read_seq(a, 1, rd, nak);
      check(rd[0], want, "flag byte");
      check({7'h0, nak}, 8'h00, "ack");
      $display("row %0d done", i);
    end
    // module reset pin clears a latched flag
    set_val(2'h0, 2'h0, 16'hF800);
    set_val(2'h0, 2'h0, NORM);
    rst_n_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    check({7'h0, sda_oe}, 8'h00, "oe in reset");
    check({7'h0, sda_drv}, 8'h00, "sda level");
    rst_n_in <= 1'b1;
    repeat (20) @(posedge clk_in);
    i_host.read_seq(BASE, 1, rd, nak);
    check(rd[0], 8'h00, "after reset");
    $display("reset test done");
    // sweep 9..33: cleared flags, reserved, vendor, monitors
    i_host.read_seq(BASE, 25, rd, nak);
    for (int j = 0; j < 25; j++)
    begin
      a = BASE + 8'(j);
      want = (a == `MODULE_TEMP_HIGH_BYTE) ? 8'h12 :
             (a == `MODULE_TEMP_LOW_BYTE)  ? 8'h34 :
             (a == `SUPPLY_VOLT_HIGH_BYTE) ? 8'h56 :
             (a == `SUPPLY_VOLT_LOW_BYTE)  ? 8'h78 : 8'h00;
      check(rd[j], want, "sweep");
    end
    $display("sweep done");
    // temperature moves between the two byte reads
    fork
      i_host.read_seq(`MODULE_TEMP_HIGH_BYTE, 2, rd, nak);
      begin
        repeat (3750) @(posedge clk_in);
        temp <= 16'hABCD;
      end
    join
    check(rd[0], 8'h12, "temp high");
    check(rd[1], 8'h34, "temp low");
    $display("sample pairing done");
    close_out();
  end
endmodule : testbench
`default_nettype wire
